// [cwr_defines.svh]
// Constants for the configuration word loader and reset sequencer
`ifndef CWR_DEFINES_SVH
`define CWR_DEFINES_SVH
// ==========================================================
// Address map of the programming port
`define CWR_CFG_SPACE_LO 14'h2000
`define CWR_CFG_WORD_ADDR 14'h2007
`define CWR_STATUS_ADDR 14'h2010
// ==========================================================
// Configuration word layout and erased value
`define CWR_CFG_ERASED 14'h3FFF
`define CWR_BIT_UNIMPL 7
`define CWR_BIT_BOR_EN 6
`define CWR_BIT_POWERUP_DELAY_TIMER_N 3
`define CWR_BIT_WDT_EN 2
`define CWR_CP_OFF 2'h3
`define CWR_CP_BASE_HALF 12'h800
`define CWR_CP_BASE_QTR 12'h400
`define CWR_CP_BASE_ALL 12'h000
// ==========================================================
// Timing
`define CWR_POWERUP_DELAY_TIMER_MS 72
`define CWR_CLK_KHZ 25000
`define CWR_POWERUP_DELAY_TIMER_CYCLES (`CWR_POWERUP_DELAY_TIMER_MS * `CWR_CLK_KHZ)
`define CWR_OST_CYCLES 1024
`define CWR_WDT_TICKS 256
`endif

// [cwr_pkg.sv]
// Types shared by the configuration loader files
package cwr_pkg;
  // Oscillator modes as coded in the configuration word
  typedef enum logic [1:0] {
    OSC_LP = 2'b00,
    OSC_XT = 2'b01,
    OSC_HS = 2'b10,
    OSC_RC = 2'b11
  } cwr_osc_e;
  // Reset sequencer states
  typedef enum logic [2:0] {
    ST_LATCH = 3'b000,
    ST_POWERUP_DELAY_TIMER = 3'b001,
    ST_OST = 3'b010,
    ST_RUN = 3'b011,
    ST_SLEEP = 3'b100
  } cwr_state_e;
endpackage

// [cwr_watchdog.sv]
// Watchdog counter clocked by the core clock, counting ticks of its own RC oscillator pin
`timescale 1ns/10ps
`include "cwr_defines.svh"
module cwr_watchdog import cwr_pkg::*; #(
  parameter int TICKS = `CWR_WDT_TICKS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Watchdog RC oscillator pin
  input wire logic rc_clk_pin,
  // Control
  input wire logic enable,
  input wire logic clear,
  // Timeout pulse
  output logic timeout
);
  localparam int W = $clog2(TICKS + 1);
  logic rc_s1_reg, rc_s2_reg, rc_s3_reg;
  logic [W-1:0] tick_reg;
  logic timeout_reg;

  // ==========================================================
  // Elaboration check
  if (TICKS < 2) begin : g_chk
    $error("watchdog period too short");
  end

  // Synchronise the RC pin, third flop for edge detect
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_s3_reg <= 1'b0;
    end else begin
      rc_s1_reg <= rc_clk_pin;
      rc_s2_reg <= rc_s1_reg;
      rc_s3_reg <= rc_s2_reg;
    end
  end

  // Count RC ticks only; main clock mode does not matter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tick_reg <= '0;
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= 1'b0;
      if (!enable || clear) begin
        tick_reg <= '0;
      end else if (rc_s2_reg && !rc_s3_reg) begin
        if (tick_reg == W'(TICKS - 1)) begin
          tick_reg <= '0;
          timeout_reg <= 1'b1;
        end else begin
          tick_reg <= tick_reg + 1'b1;
        end
      end
    end
  end

  assign timeout = timeout_reg;

  a_wdt_off_quiet: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !enable |=> !timeout_reg)
    else $error("watchdog fired while disabled");
endmodule

// [cwr_config_loader.sv]
// Configuration word store, option decode and reset sequencer
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "cwr_defines.svh"
module cwr_config_loader import cwr_pkg::*; #(
  parameter int POWERUP_DELAY_TIMER_CYCLES = `CWR_POWERUP_DELAY_TIMER_CYCLES,
  parameter int OST_CYCLES = `CWR_OST_CYCLES,
  parameter int WDT_TICKS = `CWR_WDT_TICKS
) (
  // Clock and power-on reset
  input wire logic core_clk,
  input wire logic rstn,
  // Programming port
  input wire logic prog_mode,
  input wire logic [13:0] addr,
  input wire logic [13:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [13:0] rdata,
  // External pins
  input wire logic mclr_n,
  input wire logic brownout_detect,
  input wire logic osc_clk_in,
  input wire logic wdt_rc_clk,
  // Core handshake
  input wire logic sleep_req,
  input wire logic irq_pending,
  input wire logic wdt_clear,
  // Sequencer outputs
  output logic core_reset_n,
  output logic sleeping,
  output logic powerup_delay_active,
  // Decoded options
  output logic [1:0] osc_mode_sel,
  output logic ext_clk_accept,
  output logic brownout_reset_en_bit,
  output logic [1:0] brownout_trip_sel,
  output logic watchdog_en_bit,
  output logic cp_active,
  output logic [11:0] cp_base_addr
);
  localparam int CW = 21;
  localparam int NSYNC = 4;

  // ==========================================================
  // Elaboration checks
  if (POWERUP_DELAY_TIMER_CYCLES < 1 || POWERUP_DELAY_TIMER_CYCLES >= 2 ** CW) begin : g_chk_powerup_delay_timer
    $error("power-up delay count out of range");
  end
  if (OST_CYCLES < 1 || OST_CYCLES >= 2 ** CW) begin : g_chk_ost
    $error("start-up count out of range");
  end

  // ==========================================================
  // Declarations
  logic [NSYNC-1:0] pin_async;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic prog_s, mclr_s_n, bor_s, osc_s;
  logic osc_prev_reg;
  logic osc_rise;
  logic [13:0] nv_word_reg;
  logic [13:0] act_word_reg;
  logic [13:0] rdata_reg;
  cwr_state_e state_reg, state_next;
  logic [CW-1:0] cnt_reg;
  logic pwr_type_reg;
  logic core_reset_n_reg, sleeping_reg, powerup_delay_timer_act_reg;
  logic [1:0] osc_reg, bor_trip_reg, cp_sel;
  logic ext_clk_reg, bor_en_reg, wdt_en_reg;
  logic cp_act_reg;
  logic [11:0] cp_base_reg;
  logic nv_powerup_delay_timer_on, nv_crystal;
  logic wdt_timeout;
  logic in_cfg_space;
  logic bor_trip;

  // ==========================================================
  // Pin synchronisers, two flops per pin
  assign pin_async = {osc_clk_in, brownout_detect, mclr_n, prog_mode};
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
      end else begin
        sync1_reg[i] <= pin_async[i];
        sync2_reg[i] <= sync1_reg[i];
      end
    end
  end
  assign prog_s = sync2_reg[0];
  assign mclr_s_n = sync2_reg[1];
  assign bor_s = sync2_reg[2];
  assign osc_s = sync2_reg[3];

  // Oscillator edge detect for the start-up count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_s;
    end
  end
  assign osc_rise = osc_s && !osc_prev_reg;

  // ==========================================================
  // Stored word: programming clears bits, erased value all ones
  assign in_cfg_space = (addr >= `CWR_CFG_SPACE_LO);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nv_word_reg <= `CWR_CFG_ERASED;
    end else if (wr && prog_s && addr == `CWR_CFG_WORD_ADDR) begin
      nv_word_reg <= (nv_word_reg & wdata) | 14'h0080;
    end
  end

  // Read port: data in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 14'h0000;
    end else if (rd && prog_s && addr == `CWR_CFG_WORD_ADDR) begin
      rdata_reg <= nv_word_reg | 14'h0080;
    end else if (rd && prog_s && addr == `CWR_STATUS_ADDR) begin
      rdata_reg <= {7'h00, state_reg, core_reset_n_reg, sleeping_reg,
                    pwr_type_reg, powerup_delay_timer_act_reg};
    end else begin
      rdata_reg <= 14'h0000;
    end
  end

  // ==========================================================
  // Decode of the stored word used when leaving reset
  assign nv_powerup_delay_timer_on = !nv_word_reg[`CWR_BIT_POWERUP_DELAY_TIMER_N] ||
                      nv_word_reg[`CWR_BIT_BOR_EN];
  assign nv_crystal = (nv_word_reg[1:0] != OSC_RC);
  assign bor_trip = bor_en_reg && bor_s;

  // Latch the word only while held in reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      act_word_reg <= `CWR_CFG_ERASED;
    end else if (state_reg == ST_LATCH) begin
      act_word_reg <= nv_word_reg | 14'h0080;
    end
  end

  // Option outputs follow the latched word
  assign cp_sel = nv_word_reg[13:12] & nv_word_reg[9:8] &
                  nv_word_reg[5:4];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      osc_reg <= OSC_RC;
      ext_clk_reg <= 1'b0;
      bor_en_reg <= 1'b1;
      bor_trip_reg <= 2'h3;
      wdt_en_reg <= 1'b1;
      cp_act_reg <= 1'b0;
      cp_base_reg <= `CWR_CP_BASE_ALL;
    end else if (state_reg == ST_LATCH) begin
      osc_reg <= nv_word_reg[1:0];
      ext_clk_reg <= (nv_word_reg[1:0] == OSC_HS);
      bor_en_reg <= nv_word_reg[`CWR_BIT_BOR_EN];
      bor_trip_reg <= nv_word_reg[11:10];
      wdt_en_reg <= nv_word_reg[`CWR_BIT_WDT_EN];
      cp_act_reg <= (cp_sel != `CWR_CP_OFF);
      case (cp_sel)
        2'h2: cp_base_reg <= `CWR_CP_BASE_HALF;
        2'h1: cp_base_reg <= `CWR_CP_BASE_QTR;
        default: cp_base_reg <= `CWR_CP_BASE_ALL;
      endcase
    end
  end

  // ==========================================================
  // Watchdog on its own oscillator
  cwr_watchdog #(
    .TICKS(WDT_TICKS)
  ) u_wdt (
    .core_clk(core_clk),
    .rstn(rstn),
    .rc_clk_pin(wdt_rc_clk),
    .enable(wdt_en_reg),
    .clear(wdt_clear || state_reg == ST_LATCH),
    .timeout(wdt_timeout)
  );

  // ==========================================================
  // Reset sequencer next state
  always_comb begin
    state_next = state_reg;
    if (prog_s || !mclr_s_n || bor_trip) begin
      state_next = ST_LATCH;
    end else begin
      case (state_reg)
        ST_LATCH: begin
          if (pwr_type_reg && nv_powerup_delay_timer_on) begin
            state_next = ST_POWERUP_DELAY_TIMER;
          end else if (nv_crystal) begin
            state_next = ST_OST;
          end else begin
            state_next = ST_RUN;
          end
        end
        ST_POWERUP_DELAY_TIMER: begin
          if (cnt_reg == CW'(POWERUP_DELAY_TIMER_CYCLES - 1)) begin
            state_next = (osc_reg != OSC_RC) ? ST_OST : ST_RUN;
          end
        end
        ST_OST: begin
          if (osc_rise && cnt_reg == CW'(OST_CYCLES - 1)) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          if (wdt_timeout) begin
            state_next = ST_LATCH;
          end else if (sleep_req) begin
            state_next = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wdt_timeout || irq_pending) begin
            state_next = (osc_reg != OSC_RC) ? ST_OST : ST_RUN;
          end
        end
        default: state_next = ST_LATCH;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_LATCH;
    end else begin
      state_reg <= state_next;
    end
  end

  // Power-type flag: set by power-on or brown-out, cleared on exit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pwr_type_reg <= 1'b1;
    end else if (bor_trip) begin
      pwr_type_reg <= 1'b1;
    end else if (state_reg == ST_LATCH && state_next != ST_LATCH) begin
      pwr_type_reg <= 1'b0;
    end
  end

  // Delay counter: clock cycles for the delay, oscillator edges after
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      cnt_reg <= '0;
    end else if (state_reg == ST_POWERUP_DELAY_TIMER) begin
      cnt_reg <= cnt_reg + 1'b1;
    end else if (state_reg == ST_OST && osc_rise) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Registered sequencer outputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      core_reset_n_reg <= 1'b0;
      sleeping_reg <= 1'b0;
      powerup_delay_timer_act_reg <= 1'b0;
    end else begin
      core_reset_n_reg <= (state_next == ST_RUN || state_next == ST_SLEEP);
      sleeping_reg <= (state_next == ST_SLEEP);
      powerup_delay_timer_act_reg <= (state_next == ST_POWERUP_DELAY_TIMER);
    end
  end

  // ==========================================================
  // Output assignments
  assign rdata = rdata_reg;
  assign core_reset_n = core_reset_n_reg;
  assign sleeping = sleeping_reg;
  assign powerup_delay_active = powerup_delay_timer_act_reg;
  assign osc_mode_sel = osc_reg;
  assign ext_clk_accept = ext_clk_reg;
  assign brownout_reset_en_bit = bor_en_reg;
  assign brownout_trip_sel = bor_trip_reg;
  assign watchdog_en_bit = wdt_en_reg;
  assign cp_active = cp_act_reg;
  assign cp_base_addr = cp_base_reg;

  // ==========================================================
  // Assertions
  a_unimpl_reads_one: assert property (
    @(posedge core_clk) disable iff (!rstn)
    rd && prog_s && addr == `CWR_CFG_WORD_ADDR |=> rdata[7])
    else $error("unimplemented bit read as zero");

  a_cfg_space_locked: assert property (
    @(posedge core_clk) disable iff (!rstn)
    rd && !prog_s && in_cfg_space |=> rdata == 14'h0000)
    else $error("config space readable outside programming");

  a_word_static_run: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_reg == ST_RUN && $past(state_reg) == ST_RUN
      |-> $stable(act_word_reg) && $stable(osc_mode_sel))
    else $error("options changed while running");

  a_bor_forces_powerup_delay_timer: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_reg == ST_LATCH && state_next != ST_LATCH &&
      pwr_type_reg && nv_word_reg[`CWR_BIT_BOR_EN]
      |=> powerup_delay_active)
    else $error("brown-out enabled without power-up delay");

  a_powerup_delay_timer_power_only: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_reg == ST_LATCH && !pwr_type_reg |=> state_reg != ST_POWERUP_DELAY_TIMER)
    else $error("power-up delay after non-power reset");

  a_powerup_delay_timer_length: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_reg == ST_POWERUP_DELAY_TIMER && cnt_reg == CW'(POWERUP_DELAY_TIMER_CYCLES - 1) &&
      state_next == ST_POWERUP_DELAY_TIMER |-> 1'b0)
    else $error("power-up delay overran its count");

  a_rc_skips_ost: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_reg == ST_OST |-> osc_reg != OSC_RC)
    else $error("start-up count in RC mode");

  a_ext_clk_hs: assert property (
    @(posedge core_clk) disable iff (!rstn)
    ext_clk_accept |-> osc_mode_sel == OSC_HS)
    else $error("external clock accepted outside HS mode");

  a_sleep_wake: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_reg == ST_SLEEP && irq_pending |=> state_reg != ST_SLEEP)
    else $error("interrupt failed to wake from sleep");

  a_reset_in_delay: assert property (
    @(posedge core_clk) disable iff (!rstn)
    state_reg == ST_OST |-> !core_reset_n_reg ##1
      (state_reg != ST_OST || !core_reset_n))
    else $error("core released during start-up count");
endmodule

// [cwr_prog_model.sv]
// Programmer model that drives the programming port of the loader
`timescale 1ns/10ps
module cwr_prog_model (
  // Clock
  input wire logic core_clk,
  // Programming port
  output logic prog_mode,
  output logic [13:0] addr,
  output logic [13:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [13:0] rdata
);
  // Idle port values at time zero
  initial begin
    prog_mode = 1'b0;
    addr = 14'h0000;
    wdata = 14'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Enter or leave programming mode, then let the synchroniser settle
  task automatic set_mode(input logic on, input int settle);
    @(posedge core_clk);
    prog_mode <= on;
    repeat (settle) @(posedge core_clk);
  endtask
  // One write of the word, every protection pair given the same code
  task automatic write_cfg(input logic [1:0] cp, input logic [13:0] rest);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= 14'h2007;
    wdata <= {cp, rest[11:10], cp, rest[7:6], cp, rest[3:0]};
    @(posedge core_clk);
    wr <= 1'b0;
    wdata <= ~wdata;
  endtask
  // One read; data taken in the cycle after the strobe
  task automatic read(input logic [13:0] a, output logic [13:0] d);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
endmodule

// [tb_config_word_reset_options.sv]
// Self-checking bench for the configuration loader and reset sequencer
`timescale 1ns/10ps
module tb_config_word_reset_options;
  localparam int POWERUP_DELAY_TIMER_C = 20;
  localparam int OST_C = 4;
  localparam int WDT_C = 8;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic mclr_n = 1'b0; // Held low until the word is written
  logic brownout_detect = 1'b0;
  logic osc_clk_in = 1'b0;
  logic wdt_rc_clk = 1'b0;
  logic sleep_req = 1'b0;
  logic irq_pending = 1'b0;
  logic wdt_clear = 1'b0;
  logic osc_run = 1'b0;
  logic rc_run = 1'b0;
  logic prog_mode, wr, rd;
  logic [13:0] addr, wdata, rdata;
  logic core_reset_n, sleeping, powerup_delay_active, ext_clk_accept;
  logic brownout_reset_en_bit, watchdog_en_bit, cp_active;
  logic [1:0] osc_mode_sel, brownout_trip_sel;
  logic [11:0] cp_base_addr;
  int err_total = 0;
  int n_checks = 0;
  int seed = 32'he3e530f1;

  // ==========================================================
  // Clocks
  always #20 core_clk = ~core_clk;
  // Crystal and watchdog oscillators, still while not wanted
  always @(posedge core_clk) begin
    if (osc_run) osc_clk_in <= ~osc_clk_in;
    if (rc_run) wdt_rc_clk <= ~wdt_rc_clk;
  end

  // ==========================================================
  // Design and programmer
  cwr_config_loader #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_C), .OST_CYCLES(OST_C), .WDT_TICKS(WDT_C)) u_dut (
    .core_clk(core_clk), .rstn(rstn), .prog_mode(prog_mode), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .mclr_n(mclr_n), .brownout_detect(brownout_detect),
    .osc_clk_in(osc_clk_in), .wdt_rc_clk(wdt_rc_clk), .sleep_req(sleep_req),
    .irq_pending(irq_pending), .wdt_clear(wdt_clear), .core_reset_n(core_reset_n),
    .sleeping(sleeping), .powerup_delay_active(powerup_delay_active),
    .osc_mode_sel(osc_mode_sel), .ext_clk_accept(ext_clk_accept),
    .brownout_reset_en_bit(brownout_reset_en_bit), .brownout_trip_sel(brownout_trip_sel),
    .watchdog_en_bit(watchdog_en_bit), .cp_active(cp_active), .cp_base_addr(cp_base_addr));
  cwr_prog_model u_prog (.core_clk(core_clk), .prog_mode(prog_mode), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  // ==========================================================
  // Expectations and checking
  function automatic logic [19:0] exp_opts(input logic [13:0] w);
    logic [11:0] base;
    case (w[5:4])
      2'b10: base = 12'h800;
      2'b01: base = 12'h400;
      default: base = 12'h000;
    endcase
    return {w[1:0], w[1:0] == 2'b10, w[6], w[11:10], w[2], w[5:4] != 2'b11, base};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Count delay cycles and note any time the core is held
  task automatic span(input int n, output int pd, output logic held);
    pd = 0;
    held = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (powerup_delay_active === 1'b1) pd++;
      if (core_reset_n !== 1'b1) held = 1'b1;
    end
  endtask
  task automatic wait_run(output int k);
    k = 0;
    while (core_reset_n !== 1'b1 && k < 80) begin
      @(posedge core_clk);
      #1 k++;
    end
    chk(core_reset_n, 1'b1, "core released");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Hang guard
  initial begin
    #(40 * 30000);
    err_total++;
    $display("mismatch at %0t: run timed out", $time);
    conclude();
  end

  // ==========================================================
  // Main sequence: one word per pass, every oscillator, protection and enable code met
  initial begin
    logic [13:0] r, w, d;
    logic held;
    int pd, k, src;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = 14'($random(seed));
      r[1:0] = i[1:0];
      r[6] = i[0] ^ i[2];
      r[2] = i[1] ^ i[2];
      w = {i[2:1], r[11:10], i[2:1], r[7:6], i[2:1], r[3:0]};
      if (i > 0) begin
        @(posedge core_clk);
        rstn <= 1'b0;
        mclr_n <= 1'b0;
        osc_run <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
      end
      u_prog.read(14'h2007, d);
      chk(d, 14'h0000, "read outside programming");
      u_prog.set_mode(1'b1, 3);
      u_prog.read(14'h2007, d);
      chk(d, 14'h3FFF, "erased word");
      u_prog.write_cfg(i[2:1], r);
      u_prog.read(14'h2007, d);
      chk(d, w | 14'h0080, "word readback");
      u_prog.read(14'h2008, d);
      chk(d, 14'h0000, "unmapped read");
      // Still in the first hold: power-type flag set, core held
      u_prog.read(14'h2010, d);
      chk(d, 14'h0002, "status while programming");
      u_prog.set_mode(1'b0, 0);
      mclr_n <= 1'b1;
      span(40, pd, held);
      chk(pd, (w[6] || !w[3]) ? POWERUP_DELAY_TIMER_C : 0, "power-up delay");
      chk(core_reset_n, w[1:0] == 2'b11, "held for oscillator");
      chk({osc_mode_sel, ext_clk_accept, brownout_reset_en_bit, brownout_trip_sel,
        watchdog_en_bit, cp_active, cp_base_addr}, exp_opts(w), "options");
      @(posedge core_clk);
      osc_run <= 1'b1;
      wait_run(k);
      chk(k >= OST_C || w[1:0] == 2'b11, 1'b1, "start-up count");
      // Watchdog held off by clearing, then left to expire
      @(posedge core_clk);
      wdt_clear <= 1'b1;
      rc_run <= 1'b1;
      span(40, pd, held);
      chk(held, 1'b0, "cleared watchdog");
      @(posedge core_clk);
      wdt_clear <= 1'b0;
      span(60, pd, held);
      chk(held, w[2], "watchdog timeout");
      chk(pd, 0, "no delay after watchdog");
      // Stop the RC clock and flush ticks still in the synchroniser
      @(posedge core_clk);
      rc_run <= 1'b0;
      wdt_clear <= 1'b1;
      repeat (4) @(posedge core_clk);
      wdt_clear <= 1'b0;
      wait_run(k);
      // Sleep and wake from one of the three sources
      @(posedge core_clk);
      sleep_req <= 1'b1;
      @(posedge core_clk);
      sleep_req <= 1'b0;
      span(3, pd, held);
      chk(sleeping, 1'b1, "sleep entered");
      src = (i % 3 == 2 && !w[2]) ? 0 : i % 3;
      @(posedge core_clk);
      if (src == 0) irq_pending <= 1'b1;
      else if (src == 1) mclr_n <= 1'b0;
      else rc_run <= 1'b1;
      k = 0;
      while (sleeping === 1'b1 && k < 60) begin
        @(posedge core_clk);
        #1 k++;
      end
      chk(sleeping, 1'b0, "woken");
      @(posedge core_clk);
      irq_pending <= 1'b0;
      mclr_n <= 1'b1;
      rc_run <= 1'b0;
      span(30, pd, held);
      chk(pd, 0, "no delay after wake");
      wait_run(k);
      // Brown-out pulse counts only when enabled
      @(posedge core_clk);
      brownout_detect <= 1'b1;
      repeat (3) @(posedge core_clk);
      brownout_detect <= 1'b0;
      span(40, pd, held);
      chk(held, w[6], "brown-out reset");
      chk(pd, w[6] ? POWERUP_DELAY_TIMER_C : 0, "brown-out delay");
      wait_run(k);
      chk({osc_mode_sel, ext_clk_accept, brownout_reset_en_bit, brownout_trip_sel,
        watchdog_en_bit, cp_active, cp_base_addr}, exp_opts(w), "options static");
    end
    conclude();
  end
endmodule
